// [tsr_dev.sv]
// Sensor device end: serial slave, register file, conversions, indicator.
// Assumes the front end presents codes on the system clock.
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps

module tsr_dev #(
   parameter logic [6:0] DEV_ADDR = tsr_pkg::ADDR_DEFAULT,
   parameter int CONV_PERIOD_CYC = tsr_pkg::CONV_PERIOD_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial link
   tsr_if.dev lnk,
   // Front end codes
   input wire logic [tsr_pkg::RES_W-1:0] temp_code,
   input wire logic [tsr_pkg::RES_W-1:0] conv_code,
   // Front end control and status
   output logic [2:0] channel_sel,
   output logic conv_strobe,
   output logic shutdown,
   output logic indicator_active
);
   localparam int TW = $clog2(CONV_PERIOD_CYC);

   logic [1:0] scl_sy_r, sda_sy_r, cst_sy_r;
   logic scl_hd_r, sda_hd_r, scl_f_r, sda_f_r, scl_d_r, sda_d_r, cst_d_r;
   tsr_pkg::tsr_dev_st_t st_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic rw_r;
   logic [1:0] bi_r;
   logic sda_oe_r;
   logic [7:0] ptr_r;
   logic [7:0] cfg_r;
   logic [1:0] cfg2_r;
   logic [tsr_pkg::LIM_W-1:0] hyst_r, ovt_r;
   logic [tsr_pkg::RES_W-1:0] temp_r, conv_r;
   logic [TW-1:0] tmr_r;
   logic act_r;
   logic [2:0] fq_r;
   logic strobe_r, ind_oe_r;
   wire filt_off_c = cfg2_r[0];

   // Queue length decode
   function automatic logic [2:0] fq_need(input logic [1:0] code);
      case (code)
         2'h0: fq_need = tsr_pkg::FQ_LEN0;
         2'h1: fq_need = tsr_pkg::FQ_LEN1;
         2'h2: fq_need = tsr_pkg::FQ_LEN2;
         default: fq_need = tsr_pkg::FQ_LEN3;
      endcase
   endfunction

   // Synchronisers and optional glitch filter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         scl_sy_r <= 2'h3;
         sda_sy_r <= 2'h3;
         cst_sy_r <= 2'h3;
         scl_hd_r <= 1'b1;
         sda_hd_r <= 1'b1;
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         cst_d_r <= 1'b1;
      end else begin
         scl_sy_r <= {scl_sy_r[0], lnk.scl};
         sda_sy_r <= {sda_sy_r[0], lnk.sda};
         cst_sy_r <= {cst_sy_r[0], lnk.conversion_start_pin_b};
         scl_hd_r <= scl_sy_r[1];
         sda_hd_r <= sda_sy_r[1];
         if (filt_off_c || scl_sy_r[1] == scl_hd_r) begin
            scl_f_r <= scl_sy_r[1];
         end
         if (filt_off_c || sda_sy_r[1] == sda_hd_r) begin
            sda_f_r <= sda_sy_r[1];
         end
         scl_d_r <= scl_f_r;
         sda_d_r <= sda_f_r;
         cst_d_r <= cst_sy_r[1];
      end
   end

   wire rise_c = scl_f_r & ~scl_d_r;
   wire fall_c = ~scl_f_r & scl_d_r;
   wire start_c = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
   wire stop_c = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;
   wire byte_in_c = cnt_r == 4'h8;
   wire addr_hit_c = sh_r[7:1] == DEV_ADDR;
   wire [2:0] sel_c = ptr_r[2:0];

   // Read view, unused low bits as zero
   logic [15:0] rd_word_c;
   always_comb begin
      case (sel_c)
         tsr_pkg::PTR_TEMP: rd_word_c = {temp_r, {tsr_pkg::RES_PAD{1'b0}}};
         tsr_pkg::PTR_CFG: rd_word_c = {cfg_r, 8'h00};
         tsr_pkg::PTR_HYST: rd_word_c = {hyst_r, {tsr_pkg::LIM_PAD{1'b0}}};
         tsr_pkg::PTR_OVT: rd_word_c = {ovt_r, {tsr_pkg::LIM_PAD{1'b0}}};
         tsr_pkg::PTR_CONV: rd_word_c = {conv_r, {tsr_pkg::RES_PAD{1'b0}}};
         tsr_pkg::PTR_CFG2: rd_word_c = {cfg2_r, 6'h00, 8'h00};
         default: rd_word_c = 16'h0000;
      endcase
   end
   wire [7:0] rd_byte_c = (bi_r == 2'h0) ? rd_word_c[15:8] :
      (bi_r == 2'h1) ? rd_word_c[7:0] : 8'h00;

   // Slave protocol; never drives the clock
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= tsr_pkg::DS_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         rw_r <= 1'b0;
         bi_r <= 2'h0;
         sda_oe_r <= 1'b0;
      end else if (start_c) begin
         st_r <= tsr_pkg::DS_ADDR;
         cnt_r <= 4'h0;
         bi_r <= 2'h0;
         sda_oe_r <= 1'b0;
      end else if (stop_c) begin
         st_r <= tsr_pkg::DS_IDLE;
         sda_oe_r <= 1'b0;
      end else begin
         case (st_r)
            tsr_pkg::DS_ADDR, tsr_pkg::DS_WR: begin
               if (rise_c && !byte_in_c) begin
                  sh_r <= {sh_r[6:0], sda_f_r};
                  cnt_r <= cnt_r + 4'h1;
               end else if (fall_c && byte_in_c) begin
                  sda_oe_r <= (st_r == tsr_pkg::DS_WR) || addr_hit_c;
                  if (st_r == tsr_pkg::DS_WR) begin
                     st_r <= tsr_pkg::DS_WACK;
                     bi_r <= (bi_r == 2'h3) ? bi_r : bi_r + 2'h1;
                  end else if (addr_hit_c) begin
                     st_r <= tsr_pkg::DS_AACK;
                     rw_r <= sh_r[0];
                  end else begin
                     st_r <= tsr_pkg::DS_IDLE;
                  end
               end
            end
            tsr_pkg::DS_AACK, tsr_pkg::DS_WACK: begin
               if (fall_c) begin
                  cnt_r <= 4'h0;
                  if (rw_r) begin
                     st_r <= tsr_pkg::DS_RD;
                     sh_r <= rd_byte_c;
                     sda_oe_r <= ~rd_byte_c[7];
                  end else begin
                     st_r <= tsr_pkg::DS_WR;
                     sda_oe_r <= 1'b0;
                  end
               end
            end
            tsr_pkg::DS_RD: begin
               if (fall_c && cnt_r == 4'h7) begin
                  st_r <= tsr_pkg::DS_RACK;
                  sda_oe_r <= 1'b0;
                  bi_r <= (bi_r == 2'h3) ? bi_r : bi_r + 2'h1;
               end else if (fall_c) begin
                  sh_r <= {sh_r[6:0], 1'b0};
                  sda_oe_r <= ~sh_r[6];
                  cnt_r <= cnt_r + 4'h1;
               end
            end
            tsr_pkg::DS_RACK: begin
               if (rise_c && sda_f_r) begin
                  st_r <= tsr_pkg::DS_IDLE;
               end else if (fall_c) begin
                  st_r <= tsr_pkg::DS_RD;
                  cnt_r <= 4'h0;
                  sh_r <= rd_byte_c;
                  sda_oe_r <= ~rd_byte_c[7];
               end
            end
            default: st_r <= tsr_pkg::DS_IDLE;
         endcase
      end
   end

   // Register writes
   wire wr_byte_c = (st_r == tsr_pkg::DS_WR) && fall_c && byte_in_c;
   wire wr_msb_c = wr_byte_c && bi_r == 2'h1;
   wire wr_lsb_c = wr_byte_c && bi_r == 2'h2;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ptr_r <= 8'h00;
         cfg_r <= tsr_pkg::CFG_RESET;
         cfg2_r <= tsr_pkg::CFG2_RESET;
         hyst_r <= '0;
         ovt_r <= '0;
      end else begin
         if (wr_byte_c && bi_r == 2'h0) begin
            ptr_r <= sh_r;
         end
         if (wr_msb_c && sel_c == tsr_pkg::PTR_CFG) begin
            cfg_r <= sh_r;
         end
         if (wr_msb_c && sel_c == tsr_pkg::PTR_CFG2) begin
            cfg2_r <= sh_r[tsr_pkg::CFG2_MODE:tsr_pkg::CFG2_FILT];
         end
         if (wr_msb_c && sel_c == tsr_pkg::PTR_HYST) begin
            hyst_r[tsr_pkg::LIM_W-1:1] <= sh_r;
         end
         if (wr_lsb_c && sel_c == tsr_pkg::PTR_HYST) begin
            hyst_r[0] <= sh_r[7];
         end
         if (wr_msb_c && sel_c == tsr_pkg::PTR_OVT) begin
            ovt_r[tsr_pkg::LIM_W-1:1] <= sh_r;
         end
         if (wr_lsb_c && sel_c == tsr_pkg::PTR_OVT) begin
            ovt_r[0] <= sh_r[7];
         end
      end
   end

   // Conversion scheduling
   wire sd_c = cfg_r[tsr_pkg::CFG_SD];
   wire int_c = cfg_r[tsr_pkg::CFG_INT];
   wire tmr_end_c = tmr_r == TW'(CONV_PERIOD_CYC - 1);
   wire pin_mode_c = cfg2_r[1];
   wire trig_c = !sd_c && (pin_mode_c ? (cst_d_r & ~cst_sy_r[1])
      : (tmr_end_c || stop_c));
   wire is_temp_c = cfg_r[tsr_pkg::CFG_CH_HI:tsr_pkg::CFG_CH_LO] == tsr_pkg::CH_TEMP;
   wire tconv_c = trig_c && is_temp_c;
   wire over_c = $signed(temp_code[tsr_pkg::RES_W-1:1]) > $signed(ovt_r);
   wire under_c = $signed(temp_code[tsr_pkg::RES_W-1:1]) < $signed(hyst_r);
   wire fault_c = act_r ? (under_c && !int_c) : over_c;
   wire [2:0] fq_inc_c = fq_r + 3'h1;
   wire fq_full_c = fq_inc_c >= fq_need(cfg_r[tsr_pkg::CFG_FQ_HI:tsr_pkg::CFG_FQ_LO]);
   wire rd_clr_c = (st_r == tsr_pkg::DS_AACK) && fall_c && rw_r;
   wire clr_c = int_c && (rd_clr_c || sd_c);
   wire ind_lvl_c = act_r ? cfg_r[tsr_pkg::CFG_POL] : ~cfg_r[tsr_pkg::CFG_POL];

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tmr_r <= '0;
         temp_r <= '0;
         conv_r <= '0;
         strobe_r <= 1'b0;
      end else begin
         tmr_r <= (tmr_end_c || stop_c) ? '0 : tmr_r + TW'(1);
         strobe_r <= trig_c;
         if (tconv_c) begin
            temp_r <= temp_code;
         end
         if (trig_c && !is_temp_c) begin
            conv_r <= conv_code;
         end
      end
   end

   // Indicator with fault queue
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         act_r <= 1'b0;
         fq_r <= 3'h0;
         ind_oe_r <= 1'b1;
      end else begin
         ind_oe_r <= ~ind_lvl_c;
         if (clr_c) begin
            act_r <= 1'b0;
            fq_r <= 3'h0;
         end else if (tconv_c && fault_c && fq_full_c) begin
            act_r <= ~act_r;
            fq_r <= 3'h0;
         end else if (tconv_c) begin
            fq_r <= fault_c ? fq_inc_c : 3'h0;
         end
      end
   end

   assign lnk.sda_dev_oe = sda_oe_r;
   assign lnk.overtemp_indicator_oe = ind_oe_r;
   assign channel_sel = cfg_r[tsr_pkg::CFG_CH_HI:tsr_pkg::CFG_CH_LO];
   assign conv_strobe = strobe_r;
   assign shutdown = cfg_r[tsr_pkg::CFG_SD];
   assign indicator_active = act_r;
endmodule

// [tsr_host.sv]
// Host end: two-wire master driven by a small command register port.
// Assumes a software port on the same clock; link lines are pins.
`timescale 1ns/100ps
module tsr_host #(
   parameter logic [6:0] DEV_ADDR = tsr_pkg::ADDR_DEFAULT,
   parameter bit TEMP_ONLY = 1'b0,
   parameter int QTR_CYC = tsr_pkg::SCL_QTR_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Serial link
   tsr_if.host lnk,
   // Software port
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [15:0] rdata
);
   localparam int QW = $clog2(QTR_CYC + 1);

   logic [1:0] sda_sy_r, ind_sy_r;
   tsr_pkg::tsr_host_st_t st_r;
   logic [QW-1:0] qtr_r;
   logic [1:0] qc_r;
   logic [3:0] bit_r;
   logic [2:0] bi_r;
   logic [2:0] ptr_r;
   logic rw_r, nack_r, scl_lo_r, sda_lo_r;
   logic [1:0] nb_r;
   logic [15:0] wbuf_r, rbuf_r, rdata_r;
   logic [3:0] cst_r;
   logic cst_b_r;

   wire busy_c = st_r != tsr_pkg::HS_IDLE;
   wire go_c = wr_stb && addr == tsr_pkg::HR_CTRL && !busy_c;
   wire tick_c = qtr_r == QW'(QTR_CYC - 1);
   wire [2:0] last_c = rw_r ? {1'b0, nb_r} : 3'({1'b0, nb_r} + 3'h1);
   wire rx_c = rw_r && bi_r != 3'h0;
   // Masked data bytes keep the device's fixed bits
   wire [15:0] wmask_c = (ptr_r == tsr_pkg::PTR_CFG2) ? {wbuf_r[15:6], 6'h00} :
      (ptr_r == tsr_pkg::PTR_CFG && TEMP_ONLY) ? {wbuf_r[15:8], 3'h0, wbuf_r[4:0]} :
      wbuf_r;
   wire [7:0] tx_c = (bi_r == 3'h0) ? {DEV_ADDR, rw_r} :
      (bi_r == 3'h1) ? {5'h00, ptr_r} :
      (nb_r == 2'h2 && bi_r == 3'h2) ? wmask_c[15:8] : wmask_c[7:0];
   wire [2:0] bsel_c = 3'h7 - bit_r[2:0];
   wire drv_c = (bit_r == 4'h8) ? (rx_c && bi_r != last_c) : (!rx_c && !tx_c[bsel_c]);
   wire scl_lo_c = (st_r == tsr_pkg::HS_START && qc_r == 2'h3) ||
      ((st_r == tsr_pkg::HS_BITS || st_r == tsr_pkg::HS_STOP) && qc_r < 2'h2);

   // Pin synchronisers
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sda_sy_r <= 2'h3;
         ind_sy_r <= 2'h3;
      end else begin
         sda_sy_r <= {sda_sy_r[0], lnk.sda};
         ind_sy_r <= {ind_sy_r[0], lnk.overtemp_indicator};
      end
   end

   // Bit engine
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= tsr_pkg::HS_IDLE;
         qtr_r <= '0;
         qc_r <= 2'h0;
         bit_r <= 4'h0;
         bi_r <= 3'h0;
         sda_lo_r <= 1'b0;
         scl_lo_r <= 1'b0;
         nack_r <= 1'b0;
         rbuf_r <= 16'h0000;
      end else begin
         scl_lo_r <= scl_lo_c;
         qtr_r <= (tick_c || !busy_c) ? '0 : qtr_r + QW'(1);
         if (go_c) begin
            st_r <= tsr_pkg::HS_START;
            qc_r <= 2'h0;
            bit_r <= 4'h0;
            bi_r <= 3'h0;
            nack_r <= 1'b0;
            rbuf_r <= 16'h0000;
         end else if (busy_c && tick_c) begin
            qc_r <= qc_r + 2'h1;
            case (st_r)
               tsr_pkg::HS_START: begin
                  if (qc_r == 2'h0) begin
                     sda_lo_r <= 1'b1;
                  end
                  if (qc_r == 2'h3) begin
                     st_r <= tsr_pkg::HS_BITS;
                  end
               end
               tsr_pkg::HS_BITS: begin
                  if (qc_r == 2'h0) begin
                     sda_lo_r <= drv_c;
                  end else if (qc_r == 2'h3 && bit_r != 4'h8) begin
                     bit_r <= bit_r + 4'h1;
                     if (rx_c) begin
                        rbuf_r <= {rbuf_r[14:0], sda_sy_r[1]};
                     end
                  end else if (qc_r == 2'h3) begin
                     bit_r <= 4'h0;
                     bi_r <= bi_r + 3'h1;
                     if (!rx_c && sda_sy_r[1]) begin
                        nack_r <= 1'b1;
                        st_r <= tsr_pkg::HS_STOP;
                     end else if (bi_r == last_c) begin
                        st_r <= tsr_pkg::HS_STOP;
                     end
                  end
               end
               tsr_pkg::HS_STOP: begin
                  if (qc_r == 2'h0) begin
                     sda_lo_r <= 1'b1;
                  end else if (qc_r == 2'h2) begin
                     sda_lo_r <= 1'b0;
                  end else if (qc_r == 2'h3) begin
                     st_r <= tsr_pkg::HS_IDLE;
                  end
               end
               default: st_r <= tsr_pkg::HS_IDLE;
            endcase
         end
      end
   end

   // Command registers and read port
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ptr_r <= 3'h0;
         rw_r <= 1'b0;
         nb_r <= 2'h0;
         wbuf_r <= 16'h0000;
         rdata_r <= 16'h0000;
         cst_r <= 4'h0;
         cst_b_r <= 1'b1;
      end else begin
         cst_b_r <= ~(cst_r != 4'h0);
         if (go_c) begin
            ptr_r <= wdata[2:0];
            rw_r <= wdata[tsr_pkg::CTRL_RW];
            nb_r <= wdata[tsr_pkg::CTRL_NB_LO+1:tsr_pkg::CTRL_NB_LO];
         end
         if (wr_stb && addr == tsr_pkg::HR_WDATA) begin
            wbuf_r <= wdata;
         end
         if (wr_stb && addr == tsr_pkg::HR_CONV) begin
            cst_r <= 4'(tsr_pkg::CST_PULSE_CYC);
         end else if (cst_r != 4'h0) begin
            cst_r <= cst_r - 4'h1;
         end
         if (rd_stb) begin
            case (addr)
               tsr_pkg::HR_CTRL: rdata_r <= {10'h000, nb_r, rw_r, ptr_r};
               tsr_pkg::HR_WDATA: rdata_r <= wbuf_r;
               tsr_pkg::HR_STAT: rdata_r <= {13'h0000, ind_sy_r[1], nack_r, busy_c};
               tsr_pkg::HR_RDATA: rdata_r <= rbuf_r;
               default: rdata_r <= 16'h0000;
            endcase
         end
      end
   end

   assign lnk.scl_host_oe = scl_lo_r;
   assign lnk.sda_host_oe = sda_lo_r;
   assign lnk.conversion_start_pin_b = cst_b_r;
   assign rdata = rdata_r;
endmodule

// [tsr_if.sv]
// Two-wire link between sensor device and host controller.
// Open-drain lines resolve here; low wins, released lines float high.
`timescale 1ns/100ps
interface tsr_if;
   logic scl_host_oe;
   logic sda_host_oe;
   logic sda_dev_oe;
   logic overtemp_indicator_oe;
   logic conversion_start_pin_b;
   logic scl;
   logic sda;
   logic overtemp_indicator;
   assign scl = ~scl_host_oe;
   assign sda = ~(sda_host_oe | sda_dev_oe);
   assign overtemp_indicator = ~overtemp_indicator_oe;
   modport dev (input scl, input sda, input conversion_start_pin_b,
      output sda_dev_oe, output overtemp_indicator_oe);
   modport host (input scl, input sda, input overtemp_indicator,
      output scl_host_oe, output sda_host_oe, output conversion_start_pin_b);
endinterface

// [tsr_monitor.sv]
// Checker for the two-wire link between the sensor ends.
// Assumes plain inputs wired to the interface signals by the bench.
`timescale 1ns/100ps
module tsr_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Link signals
   input wire logic scl_host_oe,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic overtemp_indicator_oe,
   input wire logic conversion_start_pin_b,
   input wire logic scl,
   input wire logic sda,
   input wire logic overtemp_indicator
);
   logic scl_q_r;
   logic sda_q_r;
   logic in_frame_r;
   logic [7:0] rise_cnt_r;
   wire scl_rise = scl & ~scl_q_r;
   wire start_seen = scl & scl_q_r & sda_q_r & ~sda;
   wire stop_seen = scl & scl_q_r & ~sda_q_r & sda;
   wire in_frame_nxt = start_seen | (in_frame_r & ~stop_seen);
   wire [7:0] rise_cnt_nxt = start_seen ? 8'h00 : rise_cnt_r + {7'h00, scl_rise & in_frame_r};
   always_ff @(posedge clk) begin
      scl_q_r <= rst_b ? scl : 1'b1;
      sda_q_r <= rst_b ? sda : 1'b1;
      in_frame_r <= rst_b & in_frame_nxt;
      rise_cnt_r <= rst_b ? rise_cnt_nxt : 8'h00;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_dev_quiet;
      !sda_dev_oe [*8];
   endsequence
   sequence s_start_pulse;
      !conversion_start_pin_b [*8] ##1 conversion_start_pin_b;
   endsequence
   a_frame_nine_bits: assert property (
      stop_seen |-> (rise_cnt_r % 8'h09) == 8'h01) else $error("Frame ended inside a byte");
   a_addr_acked: assert property (
      scl_rise && in_frame_r && rise_cnt_r == 8'h08 |-> !sda) else $error("Address not acked");
   a_idle_quiet: assert property (
      !in_frame_r |-> !sda_dev_oe) else $error("Device drives data outside a frame");
   a_start_quiet: assert property (
      start_seen |-> s_dev_quiet) else $error("Device drives data after start");
   a_dev_low_phase: assert property (
      $changed(sda_dev_oe) |-> !scl) else $error("Device changed data with clock high");
   a_scl_idle_high: assert property (
      !in_frame_r |-> scl) else $error("Clock moves outside a frame");
   a_conv_pulse_len: assert property (
      $fell(conversion_start_pin_b) |-> s_start_pulse) else $error("Start pulse length wrong");
   a_ind_idle_reset: assert property (
      $rose(rst_b) |=> overtemp_indicator) else $error("Indicator active after reset");
endmodule

// [tsr_pkg.sv]
// Shared constants and types of the temperature sensor link.
// Assumes a 125 MHz system clock on both ends.
package tsr_pkg;
   // Data register pointers
   localparam logic [2:0] PTR_TEMP = 3'h0;
   localparam logic [2:0] PTR_CFG = 3'h1;
   localparam logic [2:0] PTR_HYST = 3'h2;
   localparam logic [2:0] PTR_OVT = 3'h3;
   localparam logic [2:0] PTR_CONV = 3'h4;
   localparam logic [2:0] PTR_CFG2 = 3'h5;
   // Register widths
   localparam int REG_W = 16;
   localparam int RES_W = 10;
   localparam int LIM_W = 9;
   localparam int RES_PAD = REG_W - RES_W;
   localparam int LIM_PAD = REG_W - LIM_W;
   // Configuration fields
   localparam int CFG_CH_HI = 7;
   localparam int CFG_CH_LO = 5;
   localparam int CFG_FQ_HI = 4;
   localparam int CFG_FQ_LO = 3;
   localparam int CFG_POL = 2;
   localparam int CFG_INT = 1;
   localparam int CFG_SD = 0;
   localparam int CFG2_MODE = 7;
   localparam int CFG2_FILT = 6;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [1:0] CFG2_RESET = 2'h0;
   localparam logic [2:0] CH_TEMP = 3'h0;
   // Fault queue lengths
   localparam logic [2:0] FQ_LEN0 = 3'h1;
   localparam logic [2:0] FQ_LEN1 = 3'h2;
   localparam logic [2:0] FQ_LEN2 = 3'h4;
   localparam logic [2:0] FQ_LEN3 = 3'h6;
   // Slave address, value arbitrary
   localparam logic [6:0] ADDR_DEFAULT = 7'h2a;
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int CONV_PERIOD_US = 355;
   localparam int CONV_PERIOD_CYC = CONV_PERIOD_US * 1000 / CLK_PERIOD_NS;
   localparam int SCL_PERIOD_NS = 160;
   localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam int CST_PULSE_CYC = 8;
   // Host command port map
   localparam logic [2:0] HR_CTRL = 3'h0;
   localparam logic [2:0] HR_WDATA = 3'h1;
   localparam logic [2:0] HR_STAT = 3'h2;
   localparam logic [2:0] HR_RDATA = 3'h3;
   localparam logic [2:0] HR_CONV = 3'h4;
   localparam int CTRL_RW = 3;
   localparam int CTRL_NB_LO = 4;
   typedef enum logic [2:0] {
      DS_IDLE = 3'b000, DS_ADDR = 3'b001, DS_AACK = 3'b011, DS_WR = 3'b010,
      DS_WACK = 3'b110, DS_RD = 3'b111, DS_RACK = 3'b101
   } tsr_dev_st_t;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00, HS_START = 2'b01, HS_BITS = 2'b11, HS_STOP = 2'b10
   } tsr_host_st_t;
endpackage

// [tsr_tb.sv]
// Bench joining sensor and host ends over the link.
// Assumes host software port and front end codes are driven here.
`timescale 1ns/100ps
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [15:0] rdata;
   logic [9:0] temp_code = 10'h000;
   logic [9:0] conv_code = 10'h000;
   logic [2:0] channel_sel;
   logic conv_strobe;
   logic shutdown;
   logic indicator_active;
   logic [15:0] q;
   int n_fail = 0;
   int n_compared = 0;
   tsr_if lnk ();
   tsr_dev #(.CONV_PERIOD_CYC(200)) tsr_dev_i (.clk, .rst_b, .lnk, .temp_code, .conv_code,
      .channel_sel, .conv_strobe, .shutdown, .indicator_active);
   tsr_host tsr_host_i (.clk, .rst_b, .lnk, .addr, .wdata, .wr_stb, .rd_stb, .rdata);
   tsr_monitor tsr_monitor_i (.clk, .rst_b, .scl_host_oe(lnk.scl_host_oe),
      .sda_host_oe(lnk.sda_host_oe), .sda_dev_oe(lnk.sda_dev_oe),
      .overtemp_indicator_oe(lnk.overtemp_indicator_oe),
      .conversion_start_pin_b(lnk.conversion_start_pin_b), .scl(lnk.scl), .sda(lnk.sda),
      .overtemp_indicator(lnk.overtemp_indicator));
   initial begin
      forever #4 clk = ~clk;
   end
   function automatic logic [15:0] res_word(input logic [9:0] c);
      return {c, 6'h00};
   endfunction
   function automatic logic [15:0] lim_word(input logic [15:0] d);
      return {d[15:7], 7'h00};
   endfunction
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic sw(input logic [2:0] a, input logic [15:0] d, input logic w);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= w;
      rd_stb <= ~w;
      @(posedge clk);
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      @(posedge clk);
      q = rdata;
   endtask
   task automatic xfer(input logic [5:0] ctrl, input logic [15:0] d);
      int k;
      sw(tsr_pkg::HR_WDATA, d, 1'b1);
      sw(tsr_pkg::HR_CTRL, {10'h000, ctrl}, 1'b1);
      for (k = 0; k < 2000; k++) begin
         sw(tsr_pkg::HR_STAT, 16'h0000, 1'b0);
         if (q[0] === 1'b0) break;
      end
      check("idle", {15'h0000, q[0]}, 16'h0000);
      check("nack", {15'h0000, q[1]}, 16'h0000);
   endtask
   task automatic rd(input logic [2:0] p, input logic [1:0] nb);
      xfer({3'h0, p}, 16'h0000);
      xfer({nb, 4'h8}, 16'h0000);
      sw(tsr_pkg::HR_RDATA, 16'h0000, 1'b0);
   endtask
   task automatic wr(input logic [2:0] p, input logic [1:0] nb, input logic [15:0] d);
      xfer({nb, 1'b0, p}, d);
   endtask
   task automatic ind(input string what, input logic e);
      check(what, {15'h0000, indicator_active}, {15'h0000, e});
   endtask
   initial begin
      repeat (90000) @(posedge clk);
      n_fail++;
      test_done();
   end
   initial begin
      int i;
      int n;
      logic [9:0] t;
      logic [15:0] v;
      void'($urandom(98));
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      temp_code <= 10'h3ff;
      repeat (300) @(posedge clk);
      xfer(6'h28, 16'h0000);
      sw(tsr_pkg::HR_RDATA, 16'h0000, 1'b0);
      check("reset_ptr", q, res_word(10'h3ff));
      for (i = 0; i < 3; i++) begin
         t = (i == 0) ? 10'h200 : (i == 1) ? 10'h1fc : 10'($urandom);
         v = 16'($urandom);
         temp_code <= t;
         conv_code <= v[9:0];
         wr(tsr_pkg::PTR_CFG, 2'h1, {8'h00, v[15:8]});
         rd(tsr_pkg::PTR_CFG, 2'h1);
         check("cfg", {8'h00, q[7:0]}, {8'h00, v[15:8]});
         check("chan", {13'h0000, channel_sel}, {13'h0000, v[15:13]});
         check("sd", {15'h0000, shutdown}, {15'h0000, v[8]});
         wr(tsr_pkg::PTR_CFG, 2'h1, 16'h0080);
         wr(tsr_pkg::PTR_CFG, 2'h1, 16'h0000);
         wr(tsr_pkg::PTR_TEMP, 2'h2, 16'hffff);
         rd(tsr_pkg::PTR_TEMP, 2'h2);
         check("temp", q, res_word(t));
         rd(tsr_pkg::PTR_CONV, 2'h2);
         check("conv", q, res_word(v[9:0]));
         wr(tsr_pkg::PTR_HYST, 2'h2, v);
         wr(tsr_pkg::PTR_OVT, 2'h2, ~v);
         rd(tsr_pkg::PTR_HYST, 2'h2);
         check("hyst", q, lim_word(v));
         rd(tsr_pkg::PTR_OVT, 2'h2);
         check("ovt", q, lim_word(~v));
      end
      wr(tsr_pkg::PTR_HYST, 2'h2, 16'h1000);
      wr(tsr_pkg::PTR_OVT, 2'h2, 16'h1880);
      temp_code <= 10'h030;
      repeat (1300) @(posedge clk);
      for (i = 0; i < 4; i++) begin
         n = (i == 3) ? 6 : (1 << i);
         wr(tsr_pkg::PTR_CFG, 2'h1, {11'h000, i[1:0], i[0], 2'h0});
         temp_code <= 10'h064;
         repeat ((n - 1) * 200 + 100) @(posedge clk);
         ind("early", 1'b0);
         repeat (200) @(posedge clk);
         ind("trip", 1'b1);
         check("pin", {15'h0000, lnk.overtemp_indicator}, {15'h0000, i[0]});
         temp_code <= 10'h050;
         repeat (n * 200) @(posedge clk);
         ind("hyst", 1'b1);
         temp_code <= 10'h030;
         repeat (n * 200 + 100) @(posedge clk);
         ind("clear", 1'b0);
      end
      wr(tsr_pkg::PTR_CFG, 2'h1, 16'h0002);
      temp_code <= 10'h064;
      repeat (300) @(posedge clk);
      temp_code <= 10'h030;
      repeat (300) @(posedge clk);
      ind("int_hold", 1'b1);
      wr(tsr_pkg::PTR_CFG, 2'h1, 16'h0003);
      ind("int_sd", 1'b0);
      wr(tsr_pkg::PTR_CFG, 2'h1, 16'h0000);
      temp_code <= 10'h1fc;
      repeat (300) @(posedge clk);
      wr(tsr_pkg::PTR_CFG2, 2'h1, 16'h00ff);
      rd(tsr_pkg::PTR_CFG2, 2'h1);
      check("cfg2", {8'h00, q[7:0]}, 16'h00c0);
      temp_code <= 10'h001;
      repeat (300) @(posedge clk);
      rd(tsr_pkg::PTR_TEMP, 2'h2);
      check("pin_hold", q, res_word(10'h1fc));
      sw(tsr_pkg::HR_CONV, 16'h0000, 1'b1);
      n = 0;
      repeat (40) begin
         @(posedge clk);
         n += int'(conv_strobe);
      end
      check("strobe", 16'(n), 16'h0001);
      rd(tsr_pkg::PTR_TEMP, 2'h2);
      check("pin_conv", q, res_word(10'h001));
      test_done();
   end
endmodule
